/* File: hw/goi_top.sv */
// Graphics option interface: window decode, diag register, interrupt and reset
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module goi_top #(
   parameter int ROM_DEPTH = 256
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Module side
   input wire logic low_cost_graphics_module,
   input wire logic high_perf_graphics_module,
   input wire logic gfx_irq_req,
   input wire logic scan_test_bit,
   input wire logic osc_select,
   input wire logic bus_data_strobe_n,
   input wire logic refresh_pulse,
   // Direct processor bus access to the module
   output logic io_req,
   output logic io_write,
   output logic [31:0] io_addr,
   output logic [31:0] io_wdata,
   input wire logic io_ack,
   input wire logic [31:0] io_rdata,
   // System outputs
   output logic gfx_reset,
   output logic irq
);
   localparam int RA_W = $clog2(ROM_DEPTH);

   typedef enum logic [1:0] {
      GOI_IDLE,
      GOI_BUS,
      GOI_DONE
   } goi_state_t;

   typedef struct packed {
      goi_state_t st;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [goi_pkg::NUM_EV-1:0] status;
      logic [goi_pkg::NUM_EV-1:0] enable;
      logic mask_gfx;
      logic [3:0] rst_cnt;
      logic gfx_reset;
      logic irq;
      logic [31:0] win_addr;
      logic io_req;
      logic io_write;
      logic [31:0] io_wdata;
      logic timeout;
      logic osc;
      logic scan;
      logic [15:0] rom_word;
   } goi_state_s_t;

   goi_state_s_t s_q, s_d;

   logic [15:0] rom_mem [ROM_DEPTH];
   logic hung;
   goi_pkg::goi_win_t win;
   logic [RA_W-1:0] rom_idx;

   // Window decode of a physical address
   function automatic goi_pkg::goi_win_t win_of(input logic [31:0] a);
      if (a >= goi_pkg::MAIN_BASE && a <= goi_pkg::MAIN_LAST) begin
         return goi_pkg::GOI_WIN_MAIN;
      end else if (a >= goi_pkg::DAC_BASE && a <= goi_pkg::DAC_LAST) begin
         return goi_pkg::GOI_WIN_DAC;
      end else if (a >= goi_pkg::ROM_BASE && a <= goi_pkg::ROM_LAST) begin
         return goi_pkg::GOI_WIN_ROM;
      end else begin
         return goi_pkg::GOI_WIN_NONE;
      end
   endfunction

   // Diagnostic ROM image, cleared to a blank pattern
   initial begin
      for (int i = 0; i < ROM_DEPTH; i++) begin
         rom_mem[i] = 16'h0000;
      end
   end

   goi_hung_det u_hung (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .bus_data_strobe_n(bus_data_strobe_n),
      .refresh_pulse(refresh_pulse),
      .hung_pulse(hung)
   );

   assign win = win_of(s_q.win_addr);
   // One word per quadword: address bits below the stride are dropped
   assign rom_idx = RA_W'(s_q.win_addr >> goi_pkg::ROM_STRIDE_SHIFT);

   always_comb begin
      logic setup;
      logic [goi_pkg::NUM_EV-1:0] ev;
      logic [goi_pkg::NUM_EV-1:0] clr;
      setup = psel && !penable;
      ev = '0;
      clr = '0;
      s_d = s_q;
      s_d.ready = 1'b0;
      s_d.err = 1'b0;
      s_d.scan = scan_test_bit;
      s_d.osc = osc_select;
      s_d.rom_word = rom_mem[rom_idx];
      ev[goi_pkg::EV_GFX] = gfx_irq_req;
      ev[goi_pkg::EV_TMO] = hung;
      if (hung) begin
         s_d.timeout = 1'b1;
      end
      if (s_q.rst_cnt != 4'h0) begin
         s_d.rst_cnt = s_q.rst_cnt - 4'h1;
      end
      s_d.gfx_reset = (s_d.rst_cnt != 4'h0);
      case (s_q.st)
         GOI_IDLE: begin
            if (setup) begin
               s_d.st = GOI_BUS;
            end
         end
         GOI_BUS: begin
            if (!pwrite && paddr == goi_pkg::OFF_WIN_DATA && win != goi_pkg::GOI_WIN_ROM &&
                win != goi_pkg::GOI_WIN_NONE) begin
               // Direct read through the module window
               if (!s_q.io_req && !io_ack) begin
                  s_d.io_req = 1'b1;
                  s_d.io_write = 1'b0;
               end else if (io_ack) begin
                  s_d.io_req = 1'b0;
                  s_d.rdata = io_rdata;
                  s_d.ready = 1'b1;
                  s_d.st = GOI_DONE;
               end
            end else if (pwrite && paddr == goi_pkg::OFF_WIN_DATA &&
                         win != goi_pkg::GOI_WIN_ROM && win != goi_pkg::GOI_WIN_NONE) begin
               // Direct write through the module window
               if (!s_q.io_req && !io_ack) begin
                  s_d.io_req = 1'b1;
                  s_d.io_write = 1'b1;
                  s_d.io_wdata = pwdata;
               end else if (io_ack) begin
                  s_d.io_req = 1'b0;
                  s_d.ready = 1'b1;
                  s_d.st = GOI_DONE;
               end
            end else begin
               s_d.ready = 1'b1;
               s_d.st = GOI_DONE;
               if (pwrite) begin
                  if (paddr == goi_pkg::OFF_INT_ENABLE) begin
                     s_d.enable = pwdata[goi_pkg::NUM_EV-1:0];
                  end else if (paddr == goi_pkg::OFF_INT_CLEAR) begin
                     clr = pwdata[goi_pkg::NUM_EV-1:0];
                     if (pwdata[goi_pkg::EV_TMO]) begin
                        s_d.timeout = hung;
                     end
                  end else if (paddr == goi_pkg::OFF_MASK) begin
                     s_d.mask_gfx = pwdata[goi_pkg::MASK_GFX_BIT];
                  end else if (paddr == goi_pkg::OFF_IO_RESET) begin
                     if (pwdata[goi_pkg::IORST_GFX_BIT]) begin
                        s_d.rst_cnt = goi_pkg::GFX_RST_CYCLES;
                        s_d.gfx_reset = 1'b1;
                     end
                  end else if (paddr == goi_pkg::OFF_WIN_ADDR) begin
                     s_d.win_addr = pwdata;
                  end else if (paddr == goi_pkg::OFF_WIN_DATA) begin
                     s_d.err = 1'b1;
                     ev[goi_pkg::EV_BADWIN] = 1'b1;
                  end else if (paddr == goi_pkg::OFF_INT_STATUS ||
                               paddr == goi_pkg::OFF_CONFIG || paddr == goi_pkg::OFF_DIAG ||
                               paddr == goi_pkg::OFF_WIN_STAT) begin
                     s_d.err = 1'b0;
                  end else begin
                     s_d.err = 1'b1;
                  end
               end else begin
                  s_d.rdata = goi_pkg::RST_ZERO;
                  if (paddr == goi_pkg::OFF_INT_STATUS) begin
                     s_d.rdata[goi_pkg::NUM_EV-1:0] = s_q.status;
                  end else if (paddr == goi_pkg::OFF_INT_ENABLE) begin
                     s_d.rdata[goi_pkg::NUM_EV-1:0] = s_q.enable;
                  end else if (paddr == goi_pkg::OFF_INT_CLEAR) begin
                     s_d.rdata = goi_pkg::RST_ZERO;
                  end else if (paddr == goi_pkg::OFF_MASK) begin
                     s_d.rdata[goi_pkg::MASK_GFX_BIT] = s_q.mask_gfx;
                  end else if (paddr == goi_pkg::OFF_IO_RESET) begin
                     s_d.rdata[goi_pkg::IORST_GFX_BIT] = s_q.gfx_reset;
                  end else if (paddr == goi_pkg::OFF_CONFIG) begin
                     s_d.rdata[goi_pkg::CFG_LOWCOST_BIT] = low_cost_graphics_module;
                     s_d.rdata[goi_pkg::CFG_HIPERF_BIT] = high_perf_graphics_module;
                  end else if (paddr == goi_pkg::OFF_DIAG) begin
                     // Reserved bits stay zero
                     s_d.rdata[goi_pkg::DIAG_SCAN_BIT] = s_q.scan;
                     s_d.rdata[goi_pkg::DIAG_TMO_BIT] = s_q.timeout;
                     s_d.rdata[goi_pkg::DIAG_OSC_BIT] = s_q.osc;
                     s_d.rdata[15:0] = s_q.rom_word;
                  end else if (paddr == goi_pkg::OFF_WIN_ADDR) begin
                     s_d.rdata = s_q.win_addr;
                  end else if (paddr == goi_pkg::OFF_WIN_DATA) begin
                     if (win == goi_pkg::GOI_WIN_ROM) begin
                        s_d.rdata[15:0] = s_q.rom_word;
                     end else begin
                        s_d.err = 1'b1;
                        ev[goi_pkg::EV_BADWIN] = 1'b1;
                     end
                  end else if (paddr == goi_pkg::OFF_WIN_STAT) begin
                     s_d.rdata[1:0] = win;
                  end else begin
                     s_d.err = 1'b1;
                  end
               end
            end
         end
         GOI_DONE: begin
            s_d.st = GOI_IDLE;
         end
         default: begin
            s_d.st = GOI_IDLE;
         end
      endcase
      // Set wins over clear
      s_d.status = (s_q.status & ~clr) | ev;
      // Graphics source passes only with its mask bit open
      s_d.irq = |(s_d.status & s_d.enable & {{(goi_pkg::NUM_EV-1){1'b1}}, s_d.mask_gfx});
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.err;
   assign io_req = s_q.io_req;
   assign io_write = s_q.io_write;
   assign io_addr = s_q.win_addr;
   assign io_wdata = s_q.io_wdata;
   assign gfx_reset = s_q.gfx_reset;
   assign irq = s_q.irq;

   a_mask_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!s_q.mask_gfx && s_q.status == 3'b001) |-> !irq)
      else $error("Masked graphics interrupt reached irq");
   a_rst_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (s_q.st == GOI_BUS && psel && penable && pwrite && paddr == goi_pkg::OFF_IO_RESET &&
       pwdata[0]) |=> gfx_reset [*8])
      else $error("Graphics reset pulse too short");
   a_cfg_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (pready && !pwrite && paddr == goi_pkg::OFF_CONFIG) |->
      prdata[1:0] == $past({high_perf_graphics_module, low_cost_graphics_module}))
      else $error("Config bits wrong");
   a_scan_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (pready && !pwrite && paddr == goi_pkg::OFF_DIAG) |-> prdata[31] == $past(scan_test_bit, 2))
      else $error("Scan bit wrong");
   a_tmo_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
      hung |=> s_q.timeout && s_q.status[goi_pkg::EV_TMO])
      else $error("Timeout flag not set");
   a_osc_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (pready && !pwrite && paddr == goi_pkg::OFF_DIAG) |-> prdata[17] == $past(osc_select, 2))
      else $error("Oscillator bit wrong");
   a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (pready && !pwrite && paddr == goi_pkg::OFF_DIAG) |-> prdata[29:18] == 12'h000 && !prdata[16])
      else $error("Reserved diag bits not zero");
   a_win_main: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (s_q.win_addr == goi_pkg::MAIN_LAST) |-> win == goi_pkg::GOI_WIN_MAIN)
      else $error("Main window decode wrong");
   a_win_dac: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (s_q.win_addr == 32'h2A00_0040) |-> win == goi_pkg::GOI_WIN_NONE)
      else $error("Palette window too wide");
   a_no_dma: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(io_req) |-> $past(psel && penable))
      else $error("Module access without processor request");
   a_irq_gfx: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (s_q.status[goi_pkg::EV_GFX] && s_q.enable[goi_pkg::EV_GFX] && s_q.mask_gfx) |-> irq)
      else $error("Open graphics interrupt missing on irq");
   a_irq_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ((s_q.status & s_q.enable) == 3'b000) |-> !irq)
      else $error("Interrupt raised with no enabled source");
   a_gfx_event: assert property (@(posedge ref_clk) disable iff (sys_rst)
      gfx_irq_req |=> s_q.status[goi_pkg::EV_GFX])
      else $error("Graphics request not latched");
   a_rst_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
      gfx_reset == (s_q.rst_cnt != 4'h0))
      else $error("Graphics reset out of step with its counter");
   a_cfg_upper: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (pready && !pwrite && paddr == goi_pkg::OFF_CONFIG) |-> prdata[31:2] == 30'h0000_0000)
      else $error("Config upper bits not zero");
   a_tmo_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (pready && !pwrite && paddr == goi_pkg::OFF_DIAG) |-> prdata[30] == $past(s_q.timeout))
      else $error("Timeout bit read wrong");
   a_diag_rom: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (pready && !pwrite && paddr == goi_pkg::OFF_DIAG) |-> prdata[15:0] == $past(s_q.rom_word))
      else $error("Diag ROM field read wrong");
   a_win_main_lo: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (s_q.win_addr == 32'h27FF_FFFC) |-> win == goi_pkg::GOI_WIN_NONE)
      else $error("Main window starts too low");
   a_win_dac_lo: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (s_q.win_addr == goi_pkg::DAC_BASE) |-> win == goi_pkg::GOI_WIN_DAC)
      else $error("Palette window base not decoded");
   a_win_rom: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (s_q.win_addr == goi_pkg::ROM_BASE) |-> win == goi_pkg::GOI_WIN_ROM)
      else $error("ROM window base not decoded");
   a_win_rom_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (s_q.win_addr == 32'h2A18_0000) |-> win == goi_pkg::GOI_WIN_NONE)
      else $error("ROM window too wide");
   a_rom_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (pready && !pwrite && paddr == goi_pkg::OFF_WIN_DATA && win == goi_pkg::GOI_WIN_ROM) |->
      prdata[31:16] == 16'h0000 && !pslverr)
      else $error("ROM word not a clean 16-bit read");
   a_rom_no_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (pready && pwrite && paddr == goi_pkg::OFF_WIN_DATA && win == goi_pkg::GOI_WIN_ROM) |->
      pslverr)
      else $error("ROM window write not refused");
   a_io_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (io_req && !io_ack) |=> io_req)
      else $error("Module request dropped before answer");
   a_io_ack_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (io_req && io_ack) |=> !io_req && pready)
      else $error("Module answer not passed to the bus");
endmodule // goi_top

/* File: hw/goi_pkg.sv */
// Package of constants for the graphics option interface
package goi_pkg;
   // Physical windows decoded on the processor side
   localparam logic [31:0] MAIN_BASE = 32'h2800_0000;
   localparam logic [31:0] MAIN_LAST = 32'h29FF_FFFF;
   localparam logic [31:0] DAC_BASE = 32'h2A00_0000;
   localparam logic [31:0] DAC_LAST = 32'h2A00_003C;
   localparam logic [31:0] ROM_BASE = 32'h2A10_0000;
   localparam logic [31:0] ROM_LAST = 32'h2A17_FFFF;
   // Quadword stride of the diagnostic ROM
   localparam int ROM_STRIDE_SHIFT = 3;
   localparam int ROM_ADDR_W = 16;
   // APB control register offsets
   localparam logic [11:0] OFF_INT_STATUS = 12'h000;
   localparam logic [11:0] OFF_INT_ENABLE = 12'h004;
   localparam logic [11:0] OFF_INT_CLEAR = 12'h008;
   localparam logic [11:0] OFF_MASK = 12'h00C;
   localparam logic [11:0] OFF_IO_RESET = 12'h010;
   localparam logic [11:0] OFF_CONFIG = 12'h014;
   localparam logic [11:0] OFF_DIAG = 12'h018;
   localparam logic [11:0] OFF_WIN_ADDR = 12'h01C;
   localparam logic [11:0] OFF_WIN_DATA = 12'h020;
   localparam logic [11:0] OFF_WIN_STAT = 12'h024;
   // Field positions
   localparam int DIAG_SCAN_BIT = 31;
   localparam int DIAG_TMO_BIT = 30;
   localparam int DIAG_OSC_BIT = 17;
   localparam int MASK_GFX_BIT = 0;
   localparam int IORST_GFX_BIT = 0;
   localparam int CFG_LOWCOST_BIT = 0;
   localparam int CFG_HIPERF_BIT = 1;
   // Interrupt status layout
   localparam int EV_GFX = 0;
   localparam int EV_TMO = 1;
   localparam int EV_BADWIN = 2;
   localparam int NUM_EV = 3;
   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   // Refresh pulses with strobe low that flag a hung cycle
   localparam logic [1:0] HUNG_REFRESH_COUNT = 2'h2;
   // Graphics reset pulse length in cycles
   localparam logic [3:0] GFX_RST_CYCLES = 4'h8;
   // Window kinds
   typedef enum logic [1:0] {
      GOI_WIN_NONE,
      GOI_WIN_MAIN,
      GOI_WIN_DAC,
      GOI_WIN_ROM
   } goi_win_t;
endpackage

/* File: hw/goi_hung_det.sv */
// Hung-cycle detector counting refresh pulses under a low data strobe
`timescale 1ns/1ps
module goi_hung_det (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic bus_data_strobe_n,
   input wire logic refresh_pulse,
   output logic hung_pulse
);
   typedef struct packed {
      logic [1:0] cnt;
      logic fired;
   } goi_hd_t;
   goi_hd_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (bus_data_strobe_n) begin
         s_d.cnt = 2'h0;
         s_d.fired = 1'b0;
      end else if (refresh_pulse && !s_q.fired) begin
         // Second refresh with strobe still low flags the hang
         if (s_q.cnt + 2'h1 == goi_pkg::HUNG_REFRESH_COUNT) begin
            s_d.fired = 1'b1;
         end
         s_d.cnt = s_q.cnt + 2'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hung_pulse = s_d.fired && !s_q.fired;
endmodule // goi_hung_det

/* File: tb/goi_gfx_model.sv */
// Behavioural graphics option module on the direct processor bus
`timescale 1ns/1ps
module goi_gfx_model (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [3:0] lat,
   input wire logic io_req,
   input wire logic io_write,
   input wire logic [31:0] io_addr,
   input wire logic [31:0] io_wdata,
   output logic io_ack,
   output logic [31:0] io_rdata
);
   logic [31:0] mem_q [16];
   logic [3:0] cnt_q;
   logic done_q;
   initial begin
      io_ack = 1'b0;
      io_rdata = 32'h0000_0000;
      cnt_q = 4'h0;
      done_q = 1'b0;
      foreach (mem_q[i]) mem_q[i] = 32'h0000_0000;
   end
   // Direct read and write only, prompt or slow answer
   always @(posedge ref_clk) begin
      io_ack <= 1'b0;
      io_rdata <= ~io_rdata;
      if (sys_rst) begin
         cnt_q <= 4'h0;
         done_q <= 1'b0;
      end else if (!io_req) begin
         done_q <= 1'b0;
      end else if (!done_q) begin
         if (cnt_q >= lat) begin
            io_ack <= 1'b1;
            done_q <= 1'b1;
            cnt_q <= 4'h0;
            if (io_write) mem_q[io_addr[5:2]] <= io_wdata;
            io_rdata <= mem_q[io_addr[5:2]];
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule // goi_gfx_model

/* File: tb/goi_top_tb.sv */
// Self-checking testbench of the graphics option interface
`timescale 1ns/1ps
module goi_top_tb;
   logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, io_addr, io_wdata, io_rdata;
   logic pready, pslverr, io_req, io_write, io_ack, gfx_reset, irq;
   logic lc = 1'b1, hp = 1'b0, gfx_irq_req = 1'b0, scan_test_bit = 1'b0, osc_select = 1'b0;
   logic bus_data_strobe_n = 1'b1, refresh_pulse = 1'b0;
   logic [3:0] lat = 4'h0;
   int mismatches = 0, n_tests = 0, cyc = 0;
   always #12.5 ref_clk = ~ref_clk;
   goi_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_cost_graphics_module(lc), .high_perf_graphics_module(hp),
      .gfx_irq_req(gfx_irq_req), .scan_test_bit(scan_test_bit), .osc_select(osc_select),
      .bus_data_strobe_n(bus_data_strobe_n), .refresh_pulse(refresh_pulse), .io_req(io_req),
      .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata), .io_ack(io_ack),
      .io_rdata(io_rdata), .gfx_reset(gfx_reset), .irq(irq));
   goi_gfx_model i_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .lat(lat), .io_req(io_req),
      .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata), .io_ack(io_ack),
      .io_rdata(io_rdata));
   task automatic give_verdict;
      if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
         mismatches++;
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 200) chk(32'h0000_0000, 32'h0000_0001, "no pready");
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, {31'h0, exp_err}, "write error response");
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk({31'h0, e}, {31'h0, exp_err}, "read error response");
      if (!exp_err) chk(r, exp, "read data");
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic t_config;
      rd(goi_pkg::OFF_CONFIG, 32'h0000_0001, 1'b0);
      lc <= 1'b0;
      hp <= 1'b1;
      rd(goi_pkg::OFF_CONFIG, 32'h0000_0002, 1'b0);
      wr(goi_pkg::OFF_CONFIG, 32'h0000_0000, 1'b0);
      rd(goi_pkg::OFF_CONFIG, 32'h0000_0002, 1'b0);
      rd(12'h0FC, 32'h0000_0000, 1'b1);
   endtask
   task automatic t_diag;
      for (int i = 0; i < 4; i++) begin
         scan_test_bit <= i[1];
         osc_select <= i[0];
         rd(goi_pkg::OFF_DIAG, {i[1], 13'h0, i[0], 17'h0}, 1'b0);
      end
      scan_test_bit <= 1'b0;
      osc_select <= 1'b0;
   endtask
   task automatic pulse;
      @(posedge ref_clk);
      refresh_pulse <= 1'b1;
      @(posedge ref_clk);
      refresh_pulse <= 1'b0;
      cycles(3);
   endtask
   task automatic t_hang;
      bus_data_strobe_n <= 1'b0;
      pulse();
      bus_data_strobe_n <= 1'b1;
      pulse();
      rd(goi_pkg::OFF_DIAG, 32'h0000_0000, 1'b0);
      bus_data_strobe_n <= 1'b0;
      pulse();
      pulse();
      bus_data_strobe_n <= 1'b1;
      rd(goi_pkg::OFF_DIAG, 32'h4000_0000, 1'b0);
      rd(goi_pkg::OFF_INT_STATUS, 32'h0000_0002, 1'b0);
      wr(goi_pkg::OFF_INT_CLEAR, 32'h0000_0002, 1'b0);
      rd(goi_pkg::OFF_DIAG, 32'h0000_0000, 1'b0);
   endtask
   task automatic t_irq;
      wr(goi_pkg::OFF_INT_ENABLE, 32'h0000_0007, 1'b0);
      wr(goi_pkg::OFF_MASK, 32'h0000_0001, 1'b0);
      @(posedge ref_clk);
      gfx_irq_req <= 1'b1;
      @(posedge ref_clk);
      gfx_irq_req <= 1'b0;
      cycles(3);
      chk({31'h0, irq}, 32'h0000_0001, "irq with gate open");
      wr(goi_pkg::OFF_MASK, 32'h0000_0000, 1'b0);
      cycles(3);
      chk({31'h0, irq}, 32'h0000_0000, "irq with gate closed");
      wr(goi_pkg::OFF_MASK, 32'h0000_0001, 1'b0);
      cycles(3);
      chk({31'h0, irq}, 32'h0000_0001, "irq gate reopened");
      rd(goi_pkg::OFF_INT_STATUS, 32'h0000_0001, 1'b0);
      wr(goi_pkg::OFF_INT_CLEAR, 32'h0000_0001, 1'b0);
      cycles(3);
      chk({31'h0, irq}, 32'h0000_0000, "irq after clear");
   endtask
   task automatic t_reset;
      int n;
      n = 0;
      wr(goi_pkg::OFF_IO_RESET, 32'h0000_0001, 1'b0);
      // First pulse cycle falls on the ready edge
      if (gfx_reset === 1'b1) n++;
      repeat (40) begin
         @(posedge ref_clk);
         if (gfx_reset === 1'b1) n++;
      end
      chk(n, 32'h0000_0008, "graphics reset length");
   endtask
   task automatic t_windows;
      logic [31:0] wa [9];
      logic [1:0] ws [9];
      wa = '{goi_pkg::MAIN_BASE, goi_pkg::MAIN_LAST, goi_pkg::DAC_BASE, goi_pkg::DAC_LAST,
         goi_pkg::ROM_BASE, goi_pkg::ROM_LAST, 32'h27FF_FFFC, 32'h2A00_0040, 32'h2A18_0000};
      ws = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0};
      foreach (wa[i]) begin
         wr(goi_pkg::OFF_WIN_ADDR, wa[i], 1'b0);
         rd(goi_pkg::OFF_WIN_STAT, {30'h0, ws[i]}, 1'b0);
      end
      wr(goi_pkg::OFF_WIN_DATA, 32'h0000_0000, 1'b1);
      rd(goi_pkg::OFF_WIN_DATA, 32'h0000_0000, 1'b1);
      wr(goi_pkg::OFF_WIN_ADDR, goi_pkg::MAIN_BASE + 32'h0000_0008, 1'b0);
      wr(goi_pkg::OFF_WIN_DATA, 32'hA5A5_1234, 1'b0);
      rd(goi_pkg::OFF_WIN_DATA, 32'hA5A5_1234, 1'b0);
      lat <= 4'h6;
      wr(goi_pkg::OFF_WIN_ADDR, goi_pkg::DAC_BASE + 32'h0000_0004, 1'b0);
      wr(goi_pkg::OFF_WIN_DATA, 32'h0000_00C3, 1'b0);
      rd(goi_pkg::OFF_WIN_DATA, 32'h0000_00C3, 1'b0);
      wr(goi_pkg::OFF_WIN_ADDR, goi_pkg::MAIN_BASE + 32'h0000_000C, 1'b0);
      rd(goi_pkg::OFF_WIN_DATA, 32'h0000_0000, 1'b0);
      wr(goi_pkg::OFF_WIN_ADDR, goi_pkg::ROM_BASE + 32'h0000_0028, 1'b0);
      rd(goi_pkg::OFF_WIN_DATA, 32'h0000_0000, 1'b0);
      wr(goi_pkg::OFF_WIN_DATA, 32'h0000_FFFF, 1'b1);
      rd(goi_pkg::OFF_INT_STATUS, 32'h0000_0004, 1'b0);
      wr(goi_pkg::OFF_INT_CLEAR, 32'h0000_0004, 1'b0);
      rd(goi_pkg::OFF_INT_STATUS, 32'h0000_0000, 1'b0);
   endtask
   initial begin
      cycles(16);
      sys_rst <= 1'b0;
      chk({30'h0, irq, gfx_reset}, 32'h0000_0000, "outputs after reset");
      rd(goi_pkg::OFF_INT_STATUS, 32'h0000_0000, 1'b0);
      t_config();
      t_diag();
      t_hang();
      t_irq();
      t_reset();
      t_windows();
      give_verdict();
   end
endmodule // goi_top_tb
